// ==== upes_pkg.sv ====
// Register map, field layout and reset values of the PHY event status block.
//
// Behaviour
// - Host port unplug flags in bits 9:8: bit 8 rising, bit 9 falling edge.
// - Dual-role unplug flags in bits 7:6: bit 6 rising, bit 7 falling edge.
// - Dual-role ID flags in bits 5:4: bit 4 rising, bit 5 falling edge.
// - Dual-role B-session flags in bits 3:2: bit 2 rising, bit 3 falling.
// - Bit 1 sets on host line state change and holds until cleared.
// - Bit 0 sets on dual-role line state change and holds until cleared.
// - Clear bits 9:8: 01 clears host rising flag, 10 clears falling flag.
// - Clear bits 7:6: 01 clears dual-role unplug rising, 10 falling flag.
// - Clear bits 5:4: 01 clears ID rising flag, 10 clears falling flag.
// - Clear bits 3:2: 01 clears B-session rising, 10 clears falling flag.
// - Writing one to clear bit 1 or 0 clears that line flag; zero keeps.
// - Live status bit 10 shows dual-role avalid, reset zero.
// - Live status bit 9 shows dual-role bvalid, reset zero.
// - Each flag is captured only while its matching enable bit is set.
// - Each signal is filtered by programmable cycle count before edge detect.
`default_nettype none

package upes_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] UPES_ENABLE_OFS = 12'h110;
    localparam logic [11:0] UPES_FLAGS_OFS  = 12'h114;
    localparam logic [11:0] UPES_CLEAR_OFS  = 12'h118;
    localparam logic [11:0] UPES_MASK_OFS   = 12'h11c;
    localparam logic [11:0] UPES_LIVE_OFS   = 12'h120;
    localparam logic [11:0] UPES_LFILT_OFS  = 12'h130;
    localparam logic [11:0] UPES_DFILT_OFS  = 12'h134;
    localparam logic [11:0] UPES_BFILT_OFS  = 12'h138;
    localparam logic [11:0] UPES_IFILT_OFS  = 12'h13c;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int UPES_NFLAG      = 10;
    localparam int UPES_EN_WE_POS  = 16;
    localparam int UPES_NLIVE      = 26;
    localparam int UPES_NCHAN      = 6;
    localparam int UPES_F20_W      = 20;
    localparam int UPES_F28_W      = 28;
    localparam logic [9:0]  UPES_ENABLE_RST = 10'h000;
    localparam logic [9:0]  UPES_MASK_RST   = 10'h000;
    localparam logic [19:0] UPES_FILT20_RST = 20'h30100;
    localparam logic [27:0] UPES_FILT28_RST = 28'h0030100;

    // Filter channel numbers.
    localparam int UPES_CH_OLINE = 0;
    localparam int UPES_CH_HLINE = 1;
    localparam int UPES_CH_BSES  = 2;
    localparam int UPES_CH_ID    = 3;
    localparam int UPES_CH_ODISC = 4;
    localparam int UPES_CH_HDISC = 5;

endpackage

`default_nettype wire

// ==== upes_event_status.sv ====
// PHY event status block: signal filters, edge flags and APB registers.
`timescale 1ns/1ps
`default_nettype none

module upes_event_status
    import upes_pkg::*;
#(
    parameter logic [19:0] LINE_FILT_RST = UPES_FILT20_RST,
    parameter logic [19:0] DISC_FILT_RST = UPES_FILT20_RST,
    parameter logic [19:0] BSES_FILT_RST = UPES_FILT20_RST,
    parameter logic [27:0] ID_FILT_RST   = UPES_FILT28_RST
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Charger detection results
    input  wire logic        charger_contact_found,
    input  wire logic        charging_port_found,
    input  wire logic        dedicated_port_found,
    // Host port PHY outputs
    input  wire logic        host_ls_fs_rcv,
    input  wire logic        host_avalid,
    input  wire logic        host_bvalid,
    input  wire logic        host_disconnect,
    input  wire logic        host_iddig,
    input  wire logic [1:0]  host_linestate,
    input  wire logic        host_sessend,
    input  wire logic        host_vbusvalid,
    input  wire logic        host_vmi,
    input  wire logic        host_vpi,
    // Dual-role port PHY outputs
    input  wire logic        dual_ls_fs_rcv,
    input  wire logic        dual_avalid,
    input  wire logic        dual_bvalid,
    input  wire logic        dual_fs_xver_own,
    input  wire logic        dual_disconnect,
    input  wire logic        dual_iddig,
    input  wire logic [1:0]  dual_linestate,
    input  wire logic        dual_sessend,
    input  wire logic        dual_vbusvalid,
    input  wire logic        dual_vmi,
    input  wire logic        dual_vpi
);

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    logic [UPES_NLIVE-1:0] live_raw;
    logic [UPES_NLIVE-1:0] live_meta;
    logic [UPES_NLIVE-1:0] live_sync;

    // Bit positions of this vector are the live status register layout.
    assign live_raw = {charger_contact_found, charging_port_found,
                       dedicated_port_found, host_ls_fs_rcv,
                       host_avalid, host_bvalid, host_disconnect,
                       host_iddig, host_linestate, host_sessend,
                       host_vbusvalid, host_vmi, host_vpi,
                       dual_ls_fs_rcv, dual_avalid, dual_bvalid,
                       dual_fs_xver_own, dual_disconnect, dual_iddig,
                       dual_linestate, dual_sessend, dual_vbusvalid,
                       dual_vmi, dual_vpi};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            live_meta <= '0;
            live_sync <= '0;
        end else begin
            live_meta <= live_raw;
            live_sync <= live_meta;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic [UPES_NFLAG-1:0] enable;
    logic [UPES_NFLAG-1:0] mask;
    logic [UPES_NFLAG-1:0] flags;
    logic [19:0]           line_filt;
    logic [19:0]           disc_filt;
    logic [19:0]           bses_filt;
    logic [27:0]           id_filt;
    logic [UPES_NFLAG-1:0] next_enable;
    logic [UPES_NFLAG-1:0] next_mask;
    logic [UPES_NFLAG-1:0] next_flags;
    logic [19:0]           next_line_filt;
    logic [19:0]           next_disc_filt;
    logic [19:0]           next_bses_filt;
    logic [27:0]           next_id_filt;
    logic [UPES_NFLAG-1:0] set_ev;
    logic [UPES_NFLAG-1:0] clr_ev;
    logic [UPES_NFLAG-1:0] en_we;
    logic [31:0]           wmask;
    logic [31:0]           wdata;
    logic                  wr_acc;
    logic                  rd_setup;
    logic                  hit;
    logic [31:0]           rd_val;
    logic [31:0]           next_prdata;

    // ----------------------------------------------------------------
    // Signal filters
    // ----------------------------------------------------------------
    // A channel's filtered value follows its synchronised input only
    // after the input has differed for more than the programmed count,
    // so glitches shorter than that never reach the edge detectors.
    logic [1:0]  ch_in   [UPES_NCHAN];
    logic [27:0] ch_lim  [UPES_NCHAN];
    logic [1:0]  ch_filt [UPES_NCHAN];
    logic [1:0]  ch_prev [UPES_NCHAN];
    logic [27:0] ch_cnt  [UPES_NCHAN];

    assign ch_in[UPES_CH_OLINE]  = live_sync[5:4];
    assign ch_in[UPES_CH_HLINE]  = live_sync[17:16];
    assign ch_in[UPES_CH_BSES]   = {1'b0, live_sync[9]};
    assign ch_in[UPES_CH_ID]     = {1'b0, live_sync[6]};
    assign ch_in[UPES_CH_ODISC]  = {1'b0, live_sync[7]};
    assign ch_in[UPES_CH_HDISC]  = {1'b0, live_sync[19]};
    assign ch_lim[UPES_CH_OLINE] = {8'h00, line_filt};
    assign ch_lim[UPES_CH_HLINE] = {8'h00, line_filt};
    assign ch_lim[UPES_CH_BSES]  = {8'h00, bses_filt};
    assign ch_lim[UPES_CH_ID]    = id_filt;
    assign ch_lim[UPES_CH_ODISC] = {8'h00, disc_filt};
    assign ch_lim[UPES_CH_HDISC] = {8'h00, disc_filt};

    for (genvar c = 0; c < UPES_NCHAN; c++) begin : g_filt
        logic [1:0]  next_filt;
        logic [27:0] next_cnt;

        always_comb begin
            next_filt = ch_filt[c];
            next_cnt  = '0;
            if (ch_in[c] != ch_filt[c]) begin
                if (ch_cnt[c] >= ch_lim[c]) begin
                    next_filt = ch_in[c];
                end else begin
                    next_cnt = ch_cnt[c] + 28'h0000001;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                ch_filt[c] <= 2'h0;
                ch_prev[c] <= 2'h0;
                ch_cnt[c]  <= 28'h0000000;
            end else begin
                ch_filt[c] <= next_filt;
                ch_prev[c] <= ch_filt[c];
                ch_cnt[c]  <= next_cnt;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    always_comb begin
        set_ev[9] = ch_prev[UPES_CH_HDISC][0] & ~ch_filt[UPES_CH_HDISC][0];
        set_ev[8] = ~ch_prev[UPES_CH_HDISC][0] & ch_filt[UPES_CH_HDISC][0];
        set_ev[7] = ch_prev[UPES_CH_ODISC][0] & ~ch_filt[UPES_CH_ODISC][0];
        set_ev[6] = ~ch_prev[UPES_CH_ODISC][0] & ch_filt[UPES_CH_ODISC][0];
        set_ev[5] = ch_prev[UPES_CH_ID][0] & ~ch_filt[UPES_CH_ID][0];
        set_ev[4] = ~ch_prev[UPES_CH_ID][0] & ch_filt[UPES_CH_ID][0];
        set_ev[3] = ch_prev[UPES_CH_BSES][0] & ~ch_filt[UPES_CH_BSES][0];
        set_ev[2] = ~ch_prev[UPES_CH_BSES][0] & ch_filt[UPES_CH_BSES][0];
        set_ev[1] = ch_prev[UPES_CH_HLINE] != ch_filt[UPES_CH_HLINE];
        set_ev[0] = ch_prev[UPES_CH_OLINE] != ch_filt[UPES_CH_OLINE];
        set_ev    = set_ev & enable;
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    always_comb begin
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        wdata = pwdata & wmask;
        case (paddr)
            UPES_ENABLE_OFS,
            UPES_FLAGS_OFS,
            UPES_CLEAR_OFS,
            UPES_MASK_OFS,
            UPES_LIVE_OFS,
            UPES_LFILT_OFS,
            UPES_DFILT_OFS,
            UPES_BFILT_OFS,
            UPES_IFILT_OFS: hit = 1'b1;
            default:        hit = 1'b0;
        endcase
    end

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit;
    assign irq      = |(flags & mask);

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    always_comb begin
        next_enable    = enable;
        next_mask      = mask;
        next_line_filt = line_filt;
        next_disc_filt = disc_filt;
        next_bses_filt = bses_filt;
        next_id_filt   = id_filt;
        clr_ev         = '0;
        en_we          = wdata[UPES_EN_WE_POS +: UPES_NFLAG];
        if (wr_acc) begin
            case (paddr)
                UPES_ENABLE_OFS: begin
                    // Upper half selects which low bits this write may change.
                    next_enable = (enable & ~en_we) | (pwdata[9:0] & en_we);
                end
                UPES_CLEAR_OFS: begin
                    clr_ev = wdata[9:0];
                end
                UPES_MASK_OFS: begin
                    next_mask = (mask & ~wmask[9:0]) | wdata[9:0];
                end
                UPES_LFILT_OFS: begin
                    next_line_filt = (line_filt & ~wmask[19:0]) | wdata[19:0];
                end
                UPES_DFILT_OFS: begin
                    next_disc_filt = (disc_filt & ~wmask[19:0]) | wdata[19:0];
                end
                UPES_BFILT_OFS: begin
                    next_bses_filt = (bses_filt & ~wmask[19:0]) | wdata[19:0];
                end
                UPES_IFILT_OFS: begin
                    next_id_filt = (id_filt & ~wmask[27:0]) | wdata[27:0];
                end
                default: begin
                    next_enable = enable;
                end
            endcase
        end
        // A new event in the same cycle as its clear keeps the flag set.
        next_flags = (flags & ~clr_ev) | set_ev;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            enable    <= UPES_ENABLE_RST;
            mask      <= UPES_MASK_RST;
            flags     <= '0;
            line_filt <= LINE_FILT_RST;
            disc_filt <= DISC_FILT_RST;
            bses_filt <= BSES_FILT_RST;
            id_filt   <= ID_FILT_RST;
        end else begin
            enable    <= next_enable;
            mask      <= next_mask;
            flags     <= next_flags;
            line_filt <= next_line_filt;
            disc_filt <= next_disc_filt;
            bses_filt <= next_bses_filt;
            id_filt   <= next_id_filt;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data is captured in the setup cycle so that the access phase
    // can finish with no wait state and still present a flip-flop output.
    always_comb begin
        case (paddr)
            UPES_ENABLE_OFS: rd_val = {22'h000000, enable};
            UPES_FLAGS_OFS:  rd_val = {22'h000000, flags};
            UPES_MASK_OFS:   rd_val = {22'h000000, mask};
            UPES_LIVE_OFS:   rd_val = {6'h00, live_sync};
            UPES_LFILT_OFS:  rd_val = {12'h000, line_filt};
            UPES_DFILT_OFS:  rd_val = {12'h000, disc_filt};
            UPES_BFILT_OFS:  rd_val = {12'h000, bses_filt};
            UPES_IFILT_OFS:  rd_val = {4'h0, id_filt};
            default:         rd_val = 32'h00000000;
        endcase
        next_prdata = rd_setup ? rd_val : prdata;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

// ==== upes_event_status_monitor.sv ====
// Concurrent checks on the register port of the PHY event status block.
`timescale 1ns/1ps
`default_nettype none
module upes_event_status_monitor
    import upes_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    logic hit;
    logic rd_setup;
    assign hit = paddr inside {UPES_ENABLE_OFS, UPES_FLAGS_OFS, UPES_CLEAR_OFS,
        UPES_MASK_OFS, UPES_LIVE_OFS, UPES_LFILT_OFS, UPES_DFILT_OFS,
        UPES_BFILT_OFS, UPES_IFILT_OFS};
    assign rd_setup = psel && !penable && !pwrite;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_err_unmapped: assert property (psel && penable && !hit |-> pslverr && pready)
        else $error("unmapped access without error");
    a_err_mapped: assert property (psel && penable && hit |-> !pslverr)
        else $error("mapped access flagged as error");
    a_clear_reads_zero: assert property (rd_setup && paddr == UPES_CLEAR_OFS |=> prdata == 0)
        else $error("clear register read nonzero");
    a_flags_rsvd_zero: assert property (rd_setup && paddr == UPES_FLAGS_OFS |=> prdata[31:10] == 0)
        else $error("flag register reserved bits set");
    a_live_rsvd_zero: assert property (rd_setup && paddr == UPES_LIVE_OFS |=> prdata[31:26] == 0)
        else $error("live status reserved bits set");
    a_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data changed outside a read");
    a_reset_quiet: assert property ($rose(nrst) |-> prdata == 0 && !irq)
        else $error("outputs not quiet after reset");
    a_mask_off_quiet: assert property (psel && penable && pwrite && paddr == UPES_MASK_OFS
        && pstrb == 4'hf && pwdata[9:0] == 0 |=> !irq)
        else $error("interrupt with all sources masked");
endmodule
bind upes_event_status upes_event_status_monitor u_upes_event_status_monitor (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq)
);
`default_nettype wire

// ==== upes_phy_model.sv ====
// Behavioural model of the status outputs of the two PHY ports.
`timescale 1ns/1ps
`default_nettype none
module upes_phy_model (
    // Clock
    input  wire logic        clk_sys,
    // Requested levels and driven pins
    input  wire logic [25:0] level,
    output logic      [25:0] pin
);
    logic [25:0] prev;
    logic [1:0]  ph;
    // Every change bounces back for one cycle, as contacts do; the block must filter it.
    // The phase starts unknown and falls to the last branch, which loads a clean state.
    always @(posedge clk_sys) begin
        if (ph == 2'h0 && level !== prev) begin
            pin <= level;
            ph <= 2'h1;
        end else if (ph == 2'h1) begin
            pin <= prev;
            ph <= 2'h2;
        end else begin
            pin <= level;
            prev <= level;
            ph <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// ==== upes_event_status_test.sv ====
// Self-checking bench for the PHY event status block.
`timescale 1ns/1ps
`default_nettype none
module upes_event_status_test
    import upes_pkg::*;
;
    logic        clk_sys;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [25:0] level;
    logic [25:0] pin;
    logic [31:0] exp_q[$];
    int          error_cnt;
    int          checked;
    int          cyc;
    int          pin_tbl[4] = '{19, 7, 6, 9};
    int          flag_tbl[4] = '{8, 6, 4, 2};

    upes_event_status #(
        .LINE_FILT_RST(20'h4), .DISC_FILT_RST(20'h4), .BSES_FILT_RST(20'h4),
        .ID_FILT_RST(28'h4)
    ) u_upes_event_status (
        .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .charger_contact_found(pin[25]), .charging_port_found(pin[24]),
        .dedicated_port_found(pin[23]), .host_ls_fs_rcv(pin[22]),
        .host_avalid(pin[21]), .host_bvalid(pin[20]), .host_disconnect(pin[19]),
        .host_iddig(pin[18]), .host_linestate(pin[17:16]), .host_sessend(pin[15]),
        .host_vbusvalid(pin[14]), .host_vmi(pin[13]), .host_vpi(pin[12]),
        .dual_ls_fs_rcv(pin[11]), .dual_avalid(pin[10]), .dual_bvalid(pin[9]),
        .dual_fs_xver_own(pin[8]), .dual_disconnect(pin[7]), .dual_iddig(pin[6]),
        .dual_linestate(pin[5:4]), .dual_sessend(pin[3]),
        .dual_vbusvalid(pin[2]), .dual_vmi(pin[1]), .dual_vpi(pin[0])
    );
    upes_phy_model u_upes_phy_model (.clk_sys(clk_sys), .level(level), .pin(pin));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        @(negedge clk_sys);
        chk_rd({31'h0, irq}, {31'h0, exp});
    endtask
    // A read queues its expected word; the watcher below compares it when the data returns.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        if (!w) exp_q.push_back(d);
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set_pin(input int b, input logic v);
        @(posedge clk_sys);
        level[b] <= v;
        repeat (16) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
            chk_rd(prdata, exp_q.pop_front());
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, level} = '0;
        {error_cnt, checked, cyc} = '0;
        void'($urandom(89327));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        apb(1'b0, UPES_FLAGS_OFS, 32'h0);
        apb(1'b0, UPES_CLEAR_OFS, 32'h0);
        apb(1'b0, UPES_LIVE_OFS, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            level <= 26'($urandom());
            repeat (10) @(posedge clk_sys);
            apb(1'b0, UPES_LIVE_OFS, {6'h0, level});
            apb(1'b0, UPES_FLAGS_OFS, 32'h0);
        end
        @(posedge clk_sys);
        level <= '0;
        repeat (16) @(posedge clk_sys);
        apb(1'b1, UPES_ENABLE_OFS, 32'h03ff03ff);
        apb(1'b1, UPES_MASK_OFS, 32'h3ff);
        apb(1'b1, UPES_FLAGS_OFS, 32'h3ff);
        apb(1'b0, UPES_FLAGS_OFS, 32'h0);
        chk_irq(1'b0);
        for (int i = 0; i < 4; i++) begin
            set_pin(pin_tbl[i], 1'b1);
            apb(1'b0, UPES_FLAGS_OFS, 32'h1 << flag_tbl[i]);
            chk_irq(1'b1);
            set_pin(pin_tbl[i], 1'b0);
            apb(1'b0, UPES_FLAGS_OFS, 32'h3 << flag_tbl[i]);
            apb(1'b1, UPES_CLEAR_OFS, 32'h1 << flag_tbl[i]);
            apb(1'b0, UPES_FLAGS_OFS, 32'h2 << flag_tbl[i]);
            apb(1'b1, UPES_CLEAR_OFS, 32'h2 << flag_tbl[i]);
            apb(1'b0, UPES_FLAGS_OFS, 32'h0);
            chk_irq(1'b0);
        end
        set_pin(16, 1'b1);
        set_pin(4, 1'b1);
        apb(1'b0, UPES_FLAGS_OFS, 32'h3);
        apb(1'b1, UPES_CLEAR_OFS, 32'h0);
        apb(1'b0, UPES_FLAGS_OFS, 32'h3);
        apb(1'b1, UPES_MASK_OFS, 32'h0);
        chk_irq(1'b0);
        apb(1'b1, UPES_CLEAR_OFS, 32'h1);
        apb(1'b0, UPES_FLAGS_OFS, 32'h2);
        apb(1'b1, UPES_CLEAR_OFS, 32'h2);
        apb(1'b0, UPES_FLAGS_OFS, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
